// >>> rtl/lcdsd_core.v
// Purpose: segment LCD driver core with I2C target and display RAM
// Assumes: SCL and SDA already synchronous to clock
// Notes: analog levels shown as one shared two-bit code: 0 gnd, 1..3 bias steps
`timescale 1ns/1ps
`include "lcdsd_regs.vh"
module lcdsd_core #(
    parameter [6:0] TARGET_ADDR = 7'h3C,
    parameter OSC_DIV = `LCDSD_CLK_HZ / `LCDSD_OSC_HZ,
    parameter FIFO_DEPTH = 8
) (
    // Clock and reset
    input wire clock,
    input wire rst,
    // I2C pins
    input wire scl_in,
    input wire sda_in,
    output reg sda_out,
    output reg sda_oe,
    // LCD planes, one bit per pin, plus one shared two-bit drive level code
    output reg [7:0] backplane_outputs,
    output reg [15:0] frontplane_outputs,
    output reg [1:0] plane_level,
    output reg drive_active,
    output reg shared_pin_function_select,
    output reg regulator_enable,
    output reg [3:0] voltage_trim_code,
    output reg bias_quarter,
    output reg duty_eighth,
    output reg osc_running,
    output reg display_on,
    output reg frame_160,
    output reg [1:0] blink_rate
);
    localparam S_IDLE = 5'b00001;
    localparam S_ADDR = 5'b00010;
    localparam S_WBYTE = 5'b00100;
    localparam S_RBYTE = 5'b01000;
    localparam S_ACK = 5'b10000;

    reg [4:0] st_r;
    reg scl_d_r;
    reg sda_d_r;
    reg [7:0] sh_r;
    reg [3:0] bit_r;
    reg rd_r;
    reg addr_ok_r;
    reg acked_r;
    reg [1:0] phase_r;
    reg [7:0] cmd_r;
    reg [5:0] ptr_r;
    reg [7:0] ram_r [0:`LCDSD_RAM_DEPTH-1];
    reg [1:0] mode_r;
    reg [1:0] sys_r;
    reg frame_r;
    reg [1:0] blink_r;
    reg [5:0] iva_r;
    reg [15:0] osc_cnt_r;
    reg osc_tick_r;
    reg [7:0] div_r;
    reg [2:0] com_r;
    reg [1:0] sub_r;
    reg [14:0] blink_cnt_r;
    reg blink_ph_r;
    integer i;

    wire scl_rise = scl_in && !scl_d_r;
    wire scl_fall = !scl_in && scl_d_r;
    wire start_c = scl_in && scl_d_r && sda_d_r && !sda_in;
    wire stop_c = scl_in && scl_d_r && !sda_d_r && sda_in;
    wire [7:0] rx_byte = {sh_r[6:0], sda_in};
    wire fifo_in_ready;
    wire fifo_valid;
    wire [7:0] fifo_data;
    wire rx_push = (st_r == S_WBYTE) && scl_rise && (bit_r == 4'h7);
    wire standby = !sys_r[1];
    // Quarter duty only ever scans backplanes 0..3, even right after a duty change
    wire [2:0] com_eff = mode_r[1] ? com_r : {1'b0, com_r[1:0]};

    function [5:0] last_addr;
        input eighth;
        last_addr = eighth ? `LCDSD_LAST8 : `LCDSD_LAST4;
    endfunction

    function [5:0] next_ptr;
        input [5:0] p;
        input eighth;
        next_ptr = (p >= last_addr(eighth)) ? 6'h00 : p + 6'h01;
    endfunction

    function [14:0] blink_last;
        input [1:0] rate;
        case (rate)
        2'b01: blink_last = `LCDSD_BLINK_2HZ;
        2'b10: blink_last = `LCDSD_BLINK_1HZ;
        default: blink_last = `LCDSD_BLINK_HALFHZ;
        endcase
    endfunction

    // Bytes queue up so command decode never stalls the serial engine
    lcdsd_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH), .AW(3)) u_fifo (
        .clock(clock),
        .rst(rst),
        .in_valid(rx_push && addr_ok_r),
        .in_ready(fifo_in_ready),
        .in_data(rx_byte),
        .out_valid(fifo_valid),
        .out_ready(1'b1),
        .out_data(fifo_data)
    );

    // Serial engine
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            st_r <= S_IDLE;
            scl_d_r <= 1'b1;
            sda_d_r <= 1'b1;
            sh_r <= 8'h00;
            bit_r <= 4'h0;
            rd_r <= 1'b0;
            addr_ok_r <= 1'b0;
            acked_r <= 1'b0;
            sda_out <= 1'b0;
            sda_oe <= 1'b0;
        end else begin
            scl_d_r <= scl_in;
            sda_d_r <= sda_in;
            if (start_c) begin
                st_r <= S_ADDR;
                bit_r <= 4'h0;
                sda_oe <= 1'b0;
                addr_ok_r <= 1'b0;
            end else if (stop_c) begin
                st_r <= S_IDLE;
                sda_oe <= 1'b0;
            end else begin
                case (st_r)
                S_IDLE: begin
                    sda_oe <= 1'b0;
                end
                S_ADDR, S_WBYTE: begin
                    if (scl_rise) begin
                        sh_r <= rx_byte;
                        bit_r <= bit_r + 4'h1;
                    end
                    if (scl_fall && bit_r == 4'h8) begin
                        bit_r <= 4'h0;
                        acked_r <= 1'b0;
                        if (st_r == S_ADDR) begin
                            addr_ok_r <= (sh_r[7:1] == TARGET_ADDR);
                            rd_r <= sh_r[0];
                            sda_oe <= (sh_r[7:1] == TARGET_ADDR);
                        end else begin
                            // Full FIFO refuses the byte with a not-acknowledge
                            sda_oe <= addr_ok_r && fifo_in_ready;
                        end
                        sda_out <= 1'b0;
                        st_r <= S_ACK;
                    end
                end
                S_RBYTE: begin
                    if (scl_fall) begin
                        if (bit_r == 4'h8) begin
                            sda_oe <= 1'b0;
                            bit_r <= 4'h0;
                            st_r <= S_ACK;
                        end else begin
                            sda_out <= sh_r[7];
                            sda_oe <= !sh_r[7];
                            sh_r <= {sh_r[6:0], 1'b0};
                            bit_r <= bit_r + 4'h1;
                        end
                    end
                end
                S_ACK: begin
                    if (scl_rise) begin
                        acked_r <= !sda_in;
                    end
                    if (scl_fall) begin
                        sda_oe <= 1'b0;
                        if (!addr_ok_r) begin
                            st_r <= S_IDLE;
                        end else if (rd_r && (sda_oe || acked_r)) begin
                            sda_out <= ram_r[ptr_r[3:0]][7];
                            sda_oe <= !ram_r[ptr_r[3:0]][7];
                            sh_r <= {ram_r[ptr_r[3:0]][6:0], 1'b0};
                            bit_r <= 4'h1;
                            st_r <= S_RBYTE;
                        end else if (rd_r) begin
                            st_r <= S_IDLE;
                        end else begin
                            st_r <= S_WBYTE;
                        end
                    end
                end
                default: st_r <= S_IDLE;
                endcase
            end
        end
    end

    // Command decode, RAM and configuration
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            phase_r <= 2'b00;
            cmd_r <= 8'h00;
            ptr_r <= 6'h00;
            mode_r <= 2'b00;
            sys_r <= 2'b00;
            frame_r <= 1'b0;
            blink_r <= 2'b00;
            iva_r <= `LCDSD_IVA_RST;
            for (i = 0; i < `LCDSD_RAM_DEPTH; i = i + 1) begin
                ram_r[i] <= 8'h00;
            end
        end else begin
            // A new transfer always opens with a command byte
            if (start_c) begin
                phase_r <= 2'b00;
            end
            if (st_r == S_RBYTE && scl_fall && bit_r == 4'h8) begin
                ptr_r <= next_ptr(ptr_r, mode_r[1]);
            end
            if (fifo_valid) begin
                case (phase_r)
                2'b00: begin
                    cmd_r <= fifo_data;
                    phase_r <= 2'b01;
                end
                2'b01: begin
                    phase_r <= 2'b00;
                    case (cmd_r)
                    `LCDSD_CMD_DATA: begin
                        ptr_r <= fifo_data[5:0] & `LCDSD_ADDR_MASK;
                        phase_r <= 2'b10;
                    end
                    `LCDSD_CMD_MODE: mode_r <= fifo_data[1:0];
                    `LCDSD_CMD_SYS: sys_r <= fifo_data[1:0];
                    `LCDSD_CMD_FRAME: frame_r <= fifo_data[0];
                    `LCDSD_CMD_BLINK: blink_r <= fifo_data[1:0];
                    `LCDSD_CMD_IVA: iva_r <= fifo_data[5:0];
                    default: phase_r <= 2'b00;
                    endcase
                end
                2'b10: begin
                    ram_r[ptr_r[3:0]] <= fifo_data;
                    ptr_r <= next_ptr(ptr_r, mode_r[1]);
                end
                default: phase_r <= 2'b00;
                endcase
            end
        end
    end

    // Oscillator model and frame timing
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            osc_cnt_r <= 16'h0000;
            osc_tick_r <= 1'b0;
            div_r <= 8'h00;
            sub_r <= 2'b00;
            com_r <= 3'h0;
            blink_cnt_r <= 15'h0000;
            blink_ph_r <= 1'b0;
        end else if (standby) begin
            osc_cnt_r <= 16'h0000;
            osc_tick_r <= 1'b0;
        end else begin
            osc_tick_r <= (osc_cnt_r == OSC_DIV[15:0] - 16'h0001);
            osc_cnt_r <= (osc_cnt_r == OSC_DIV[15:0] - 16'h0001) ? 16'h0000 : osc_cnt_r + 16'h0001;
            if (osc_tick_r) begin
                // Each backplane slot is split in two; polarity (sub_r[1]) flips from one slot to the next
                if (div_r == 8'h00) begin
                    div_r <= frame_r ? `LCDSD_SLOT_160 : `LCDSD_SLOT_80;
                    sub_r <= sub_r + 2'b01;
                    if (sub_r[0]) begin
                        com_r <= (mode_r[1] || com_eff != 3'h3) ? com_eff + 3'h1 : 3'h0;
                    end
                end else begin
                    div_r <= div_r - 8'h01;
                end
            end
            // Blink off clears the phase at once, so the display never sticks dark
            if (blink_r == 2'b00) begin
                blink_cnt_r <= 15'h0000;
                blink_ph_r <= 1'b0;
            end else if (osc_tick_r) begin
                if (blink_cnt_r >= blink_last(blink_r)) begin
                    blink_cnt_r <= 15'h0000;
                    blink_ph_r <= !blink_ph_r;
                end else begin
                    blink_cnt_r <= blink_cnt_r + 15'h0001;
                end
            end
        end
    end

    // Plane drive, straight from RAM every cycle
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            backplane_outputs <= 8'hFF;
            frontplane_outputs <= 16'hFFFF;
            plane_level <= 2'b11;
            drive_active <= 1'b0;
            shared_pin_function_select <= 1'b1;
            regulator_enable <= 1'b1;
            voltage_trim_code <= 4'h0;
            bias_quarter <= 1'b0;
            duty_eighth <= 1'b0;
            osc_running <= 1'b0;
            display_on <= 1'b0;
            frame_160 <= 1'b0;
            blink_rate <= 2'b00;
        end else begin
            shared_pin_function_select <= iva_r[5];
            regulator_enable <= iva_r[4];
            voltage_trim_code <= iva_r[3:0];
            bias_quarter <= mode_r[0];
            duty_eighth <= mode_r[1];
            osc_running <= sys_r[1];
            display_on <= sys_r[1] && sys_r[0];
            frame_160 <= frame_r;
            blink_rate <= blink_r;
            drive_active <= sys_r[1] && sys_r[0] && !blink_ph_r;
            if (!(sys_r[1] && sys_r[0]) || blink_ph_r) begin
                // Idle planes rest at the drive level, as after reset
                plane_level <= 2'b11;
                backplane_outputs <= 8'hFF;
                frontplane_outputs <= 16'hFFFF;
            end else begin
                plane_level <= {sub_r[1], mode_r[0]};
                for (i = 0; i < 8; i = i + 1) begin
                    backplane_outputs[i] <= (com_eff == i[2:0]);
                end
                for (i = 0; i < 16; i = i + 1) begin
                    if (mode_r[1]) begin
                        frontplane_outputs[i] <= ram_r[i][com_r] ^ sub_r[1];
                    end else begin
                        frontplane_outputs[i] <= ram_r[(i + 4) >> 1][((i & 1) << 2) + com_r[1:0]] ^ sub_r[1];
                    end
                end
                if (!mode_r[1]) begin
                    backplane_outputs[7:4] <= {ram_r[1][4 + com_r[1:0]], ram_r[1][com_r[1:0]],
                                               ram_r[0][4 + com_r[1:0]], ram_r[0][com_r[1:0]]};
                end
            end
        end
    end
endmodule // lcdsd_core

// >>> rtl/lcdsd_regs.vh
// Purpose: constants for the segment LCD driver core
// Assumes: 20 MHz system clock, I2C target behind plain pins
// Notes: included by the core design file only
`ifndef LCDSD_REGS_VH
`define LCDSD_REGS_VH
`define LCDSD_CMD_DATA 8'h80
`define LCDSD_CMD_MODE 8'h82
`define LCDSD_CMD_SYS 8'h84
`define LCDSD_CMD_FRAME 8'h86
`define LCDSD_CMD_BLINK 8'h88
`define LCDSD_CMD_IVA 8'h8A
`define LCDSD_IVA_RST 6'h30
`define LCDSD_ADDR_MASK 6'h3F
`define LCDSD_LAST4 6'h09
`define LCDSD_LAST8 6'h0F
`define LCDSD_RAM_DEPTH 16
`define LCDSD_OSC_HZ 32768
`define LCDSD_CLK_HZ 20000000
`define LCDSD_FRAME_HZ 80
`define LCDSD_BLINK_BASE_HZ 2
`define LCDSD_BLINK_2HZ 15'h1FFF
`define LCDSD_BLINK_1HZ 15'h3FFF
`define LCDSD_BLINK_HALFHZ 15'h7FFF
`define LCDSD_SLOT_80 8'h19
`define LCDSD_SLOT_160 8'h0C
`endif

// >>> rtl/lcdsd_fifo.v
// Purpose: small synchronous FIFO for received bytes
// Assumes: one clock, single writer and reader
// Notes: read data is registered
`timescale 1ns/1ps
module lcdsd_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 8,
    parameter AW = 3
) (
    // Clock and reset
    input wire clock,
    input wire rst,
    // Fill side
    input wire in_valid,
    output wire in_ready,
    input wire [WIDTH-1:0] in_data,
    // Drain side
    output reg out_valid,
    input wire out_ready,
    output reg [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] mem_r [0:DEPTH-1];
    reg [AW:0] wp_r;
    reg [AW:0] rp_r;
    wire [AW:0] count = wp_r - rp_r;
    wire empty = (count == {(AW+1){1'b0}});
    wire pop = !empty && (!out_valid || out_ready);
    assign in_ready = (count != DEPTH[AW:0]) || (DEPTH[AW:0] == {(AW+1){1'b0}} && !count[AW]);
    always @(posedge clock) begin
        if (in_valid && in_ready) begin
            mem_r[wp_r[AW-1:0]] <= in_data;
        end
    end
    always @(posedge clock or posedge rst) begin
        if (rst) begin
            wp_r <= {(AW+1){1'b0}};
            rp_r <= {(AW+1){1'b0}};
            out_valid <= 1'b0;
            out_data <= {WIDTH{1'b0}};
        end else begin
            if (in_valid && in_ready) begin
                wp_r <= wp_r + 1'b1;
            end
            if (pop) begin
                out_data <= mem_r[rp_r[AW-1:0]];
                rp_r <= rp_r + 1'b1;
                out_valid <= 1'b1;
            end else if (out_ready) begin
                out_valid <= 1'b0;
            end
        end
    end
endmodule // lcdsd_fifo

// >>> tb/lcdsd_host.sv
// Purpose: I2C controller model standing in for the host
// Assumes: open-drain data line, pull-up resolved by the bench; SCL driven directly
// Notes: changes lines one step after a rising clock edge
`timescale 1ns/1ps
module lcdsd_host #(parameter int H = 4) (
    // Clock
    input wire logic clock,
    // Resolved data line
    input wire logic sda_line,
    // Driven lines
    output logic scl,
    output logic sda_low
);
    initial begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    // One cycle of settle after SCL low, so data never moves with SCL
    task automatic clk_bit(input logic b, output logic v);
        sda_low = !b;
        tick(H);
        scl = 1'b1;
        tick(H);
        v = sda_line;
        scl = 1'b0;
        tick(1);
    endtask
    task automatic start();
        sda_low = 1'b1;
        tick(H);
        scl = 1'b0;
        tick(H);
    endtask
    task automatic stop();
        sda_low = 1'b1;
        tick(H);
        scl = 1'b1;
        tick(H);
        sda_low = 1'b0;
        tick(H);
    endtask
    task automatic wr_byte(input logic [7:0] d, output logic ack);
        logic v;
        for (int i = 7; i >= 0; i--) clk_bit(d[i], v);
        clk_bit(1'b1, v);
        ack = !v;
    endtask
    task automatic rd_byte(output logic [7:0] d, input logic last);
        logic v;
        for (int i = 7; i >= 0; i--) begin
            clk_bit(1'b1, v);
            d[i] = v;
        end
        clk_bit(last, v);
    endtask
endmodule // lcdsd_host

// >>> tb/lcdsd_core_assertions.sv
// Purpose: port-level checker for the LCD driver core
// Assumes: single clock domain, async high reset
// Notes: plane checks guarded one cycle to allow registered lag
`timescale 1ns/1ps
module lcdsd_core_checker (
    // Clock and reset
    input logic clock,
    input logic rst,
    // I2C pins
    input logic scl_in,
    input logic sda_in,
    input logic sda_out,
    input logic sda_oe,
    // Planes and config
    input logic [7:0] backplane_outputs,
    input logic [15:0] frontplane_outputs,
    input logic [1:0] plane_level,
    input logic drive_active,
    input logic shared_pin_function_select,
    input logic regulator_enable,
    input logic [3:0] voltage_trim_code,
    input logic bias_quarter,
    input logic duty_eighth,
    input logic osc_running,
    input logic display_on,
    input logic frame_160,
    input logic [1:0] blink_rate
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    property p_rst_planes;
        $fell(rst) |-> backplane_outputs == 8'hFF && frontplane_outputs == 16'hFFFF && !display_on && !osc_running;
    endproperty
    a_rst_planes: assert property (p_rst_planes) else $error("planes or state not at reset level");
    property p_rst_cfg;
        $fell(rst) |-> !duty_eighth && !bias_quarter && !frame_160 && blink_rate == 2'h0;
    endproperty
    a_rst_cfg: assert property (p_rst_cfg) else $error("display config not at default");
    property p_rst_iva;
        $fell(rst) |-> regulator_enable && shared_pin_function_select && voltage_trim_code == 4'h0;
    endproperty
    a_rst_iva: assert property (p_rst_iva) else $error("voltage config not at default");
    property p_disp_osc;
        display_on |-> osc_running;
    endproperty
    a_disp_osc: assert property (p_disp_osc) else $error("display on without oscillator");
    property p_off_blank;
        !display_on && !$past(display_on) |-> backplane_outputs == 8'hFF && frontplane_outputs == 16'hFFFF;
    endproperty
    a_off_blank: assert property (p_off_blank) else $error("planes move while display off");
    property p_halt;
        (!osc_running) [*2] |-> $stable(backplane_outputs);
    endproperty
    a_halt: assert property (p_halt) else $error("scan runs without oscillator");
    property p_duty4;
        drive_active && $past(drive_active) && !duty_eighth && !$past(duty_eighth) |-> $onehot(backplane_outputs[3:0]);
    endproperty
    a_duty4: assert property (p_duty4) else $error("quarter duty scan not one-hot");
    property p_duty8;
        drive_active && $past(drive_active) && duty_eighth && $past(duty_eighth) |-> $onehot(backplane_outputs);
    endproperty
    a_duty8: assert property (p_duty8) else $error("eighth duty scan not one-hot");
    property p_sda_low;
        sda_oe |-> !sda_out;
    endproperty
    a_sda_low: assert property (p_sda_low) else $error("data pin driven high");
    property p_sda_scl;
        $changed(sda_oe) |-> !scl_in;
    endproperty
    a_sda_scl: assert property (p_sda_scl) else $error("data pin moved while clock high");
    c_disp: cover property ($rose(display_on));
    c_duty8: cover property (duty_eighth && drive_active);
    c_ack: cover property ($rose(sda_oe));
endmodule // lcdsd_core_checker
bind lcdsd_core lcdsd_core_checker chk_u (.clock(clock), .rst(rst), .scl_in(scl_in), .sda_in(sda_in),
    .sda_out(sda_out), .sda_oe(sda_oe), .backplane_outputs(backplane_outputs),
    .frontplane_outputs(frontplane_outputs), .plane_level(plane_level), .drive_active(drive_active),
    .shared_pin_function_select(shared_pin_function_select), .regulator_enable(regulator_enable),
    .voltage_trim_code(voltage_trim_code), .bias_quarter(bias_quarter), .duty_eighth(duty_eighth),
    .osc_running(osc_running), .display_on(display_on), .frame_160(frame_160), .blink_rate(blink_rate));

// >>> tb/test_lcd_segment_driver_core.sv
// Purpose: self-checking bench for the LCD driver core
// Assumes: short oscillator divider to keep the run brief
// Notes: each write transaction starts with its own command byte
`timescale 1ns/1ps
module test_lcd_segment_driver_core;
    localparam [6:0] TA = 7'h3C;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic scl, sda_low, sda_line, sda_out, sda_oe, drive_active, shared_pin_function_select;
    logic regulator_enable, bias_quarter, duty_eighth, osc_running, display_on, frame_160;
    logic [7:0] backplane_outputs;
    logic [15:0] frontplane_outputs;
    logic [1:0] plane_level, blink_rate;
    logic [3:0] voltage_trim_code;
    int miscompares = 0;
    int checked = 0;
    // Wired-AND with pull-up
    assign sda_line = ~(sda_low | sda_oe);
    lcdsd_core #(.TARGET_ADDR(TA), .OSC_DIV(4)) dut_u (.clock(clock), .rst(rst), .scl_in(scl), .sda_in(sda_line),
        .sda_out(sda_out), .sda_oe(sda_oe), .backplane_outputs(backplane_outputs),
        .frontplane_outputs(frontplane_outputs), .plane_level(plane_level), .drive_active(drive_active),
        .shared_pin_function_select(shared_pin_function_select), .regulator_enable(regulator_enable),
        .voltage_trim_code(voltage_trim_code), .bias_quarter(bias_quarter), .duty_eighth(duty_eighth),
        .osc_running(osc_running), .display_on(display_on), .frame_160(frame_160), .blink_rate(blink_rate));
    lcdsd_host host_u (.clock(clock), .sda_line(sda_line), .scl(scl), .sda_low(sda_low));
    initial forever #25 clock = ~clock;
    task automatic summarize();
        $display("Comparisons %0d, mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic send(input logic [7:0] b, input logic exp_ack);
        logic a;
        host_u.wr_byte(b, a);
        check("ack", a, exp_ack);
    endtask
    task automatic cmd(input logic [7:0] c, input logic [7:0] a);
        host_u.start();
        send({TA, 1'b0}, 1'b1);
        send(c, 1'b1);
        send(a, 1'b1);
        host_u.stop();
        host_u.tick(4);
    endtask
    task automatic wr_ram(input logic [7:0] a, input logic [7:0] d0, input logic [7:0] d1, input logic [7:0] d2);
        host_u.start();
        send({TA, 1'b0}, 1'b1);
        send(8'h80, 1'b1);
        send(a, 1'b1);
        send(d0, 1'b1);
        send(d1, 1'b1);
        send(d2, 1'b1);
        host_u.stop();
        host_u.tick(4);
    endtask
    task automatic sc_reset();
        check("bp", backplane_outputs, 8'hFF);
        check("fp", frontplane_outputs, 16'hFFFF);
        check("osc_disp", {osc_running, display_on}, 2'h0);
        check("cfg", {duty_eighth, bias_quarter, frame_160, blink_rate}, 5'h00);
        check("iva", {shared_pin_function_select, regulator_enable, voltage_trim_code}, 6'h30);
        check("lvl_idle", {drive_active, plane_level, sda_oe, sda_out}, 5'h0C);
    endtask
    task automatic sc_config();
        logic [7:0] iva [3] = '{8'h1F, 8'h25, 8'h30};
        logic [7:0] sys [3] = '{8'h02, 8'h03, 8'h01};
        logic [1:0] sys_exp [3] = '{2'h2, 2'h3, 2'h0};
        for (int i = 0; i < 4; i++) begin
            cmd(8'h82, i[7:0]);
            check("mode", {duty_eighth, bias_quarter}, i[1:0]);
            cmd(8'h88, 8'hFC | i[7:0]);
            check("blink", blink_rate, i[1:0]);
        end
        for (int i = 1; i >= 0; i--) begin
            cmd(8'h86, i[7:0]);
            check("frame", frame_160, i[0]);
        end
        for (int i = 0; i < 3; i++) begin
            cmd(8'h8A, iva[i]);
            check("iva", {shared_pin_function_select, regulator_enable, voltage_trim_code}, iva[i][5:0]);
            cmd(8'h84, sys[i]);
            check("sys", {osc_running, display_on}, sys_exp[i]);
        end
    endtask
    // Wrong target address must leave config alone
    task automatic sc_refuse();
        host_u.start();
        send({TA ^ 7'h01, 1'b0}, 1'b0);
        send(8'h88, 1'b0);
        send(8'h01, 1'b0);
        host_u.stop();
        host_u.tick(4);
        check("blink_kept", blink_rate, 2'h3);
    endtask
    task automatic sc_ram();
        logic [7:0] exp [3] = '{8'hA5, 8'h3C, 8'h96};
        logic [7:0] d;
        cmd(8'h82, 8'h00);
        wr_ram(8'h48, 8'hA5, 8'h3C, 8'h96);
        host_u.start();
        send({TA, 1'b0}, 1'b1);
        send(8'h80, 1'b1);
        send(8'h48, 1'b1);
        host_u.stop();
        host_u.start();
        send({TA, 1'b1}, 1'b1);
        for (int k = 0; k < 3; k++) begin
            host_u.rd_byte(d, k == 2);
            check("ram", d, exp[k]);
        end
        host_u.stop();
    endtask
    task automatic sc_pixels();
        cmd(8'h82, 8'h02);
        wr_ram(8'h00, 8'hFF, 8'h00, 8'h00);
        cmd(8'h84, 8'h03);
        host_u.tick(50);
        repeat (16) begin
            host_u.tick(7);
            check("fp_pair", frontplane_outputs[0] ^ frontplane_outputs[1], 1'b1);
            check("bp_onehot", $onehot(backplane_outputs), 1'b1);
            check("drive", {drive_active, plane_level[0]}, 2'h2);
        end
        wr_ram(8'h00, 8'h00, 8'h00, 8'h00);
        host_u.tick(8);
        check("fp_same", frontplane_outputs[0] ^ frontplane_outputs[1], 1'b0);
        cmd(8'h84, 8'h00);
        check("standby", {osc_running, display_on, backplane_outputs}, 10'h0FF);
        check("standby_lvl", {drive_active, plane_level}, 3'h3);
    endtask
    // Hang guard
    initial begin
        repeat (90000) @(posedge clock);
        miscompares++;
        summarize();
    end
    initial begin
        repeat (20) @(posedge clock);
        #1 rst = 1'b0;
        host_u.tick(20000);
        sc_reset();
        sc_config();
        sc_refuse();
        sc_ram();
        sc_pixels();
        summarize();
    end
endmodule // test_lcd_segment_driver_core
